// File: bench/agcs_checker.sv
// Port assertions for the gain and carrier sense configuration block
`timescale 1ns/1ps
module agcs_checker (
    input wire       i_clk_sys,
    input wire       i_rst,
    input wire       i_ce,
    input wire [5:0] i_reg_addr,
    input wire       i_reg_wr,
    input wire       i_reg_rd,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire [2:0] o_digital_gain_top_step,
    input wire [7:0] o_front_amp_cut_tenth_db,
    input wire [5:0] o_amplitude_setpoint_db,
    input wire       o_reduce_first_amp_first,
    input wire       o_cs_absolute,
    input wire       o_cs_relative
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    reg  [7:0] ra_q;
    reg  [6:0] rb_q;
    wire       wa = i_ce && i_reg_wr && i_reg_addr == 6'h1b;
    wire       wb = i_ce && i_reg_wr && i_reg_addr == 6'h1c;
    wire       rda = i_ce && i_reg_rd && i_reg_addr == 6'h1b;
    wire       rdb = i_ce && i_reg_rd && i_reg_addr == 6'h1c;
    // Shadows of the fields; decodes may lag them by one more edge
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ra_q <= 8'h03;
            rb_q <= 7'h40;
        end else begin
            if (wa) ra_q <= i_reg_wdata;
            if (wb) rb_q <= i_reg_wdata[6:0];
        end
    end
    property p_top; wa |-> ##[1:2] o_digital_gain_top_step == 3'h7 - {1'b0, ra_q[7:6]}; endproperty
    a_top: assert property (p_top) else $error("top step wrong");
    property p_cut0; wa && i_reg_wdata[5:3] == 3'h0 |-> ##[1:2] o_front_amp_cut_tenth_db == 8'h00;
    endproperty
    a_cut0: assert property (p_cut0) else $error("full gain not kept");
    property p_cut7; wa && i_reg_wdata[5:3] == 3'h7 |-> ##[1:2] o_front_amp_cut_tenth_db == 8'hab;
    endproperty
    a_cut7: assert property (p_cut7) else $error("largest cut wrong");
    property p_sp; wa && i_reg_wdata[2:0] == 3'h0 |-> ##[1:2] o_amplitude_setpoint_db == 6'h18;
    endproperty
    a_sp: assert property (p_sp) else $error("lowest setpoint wrong");
    property p_ord; wb |-> ##[1:2] o_reduce_first_amp_first == rb_q[6]; endproperty
    a_ord: assert property (p_ord) else $error("order bit wrong");
    property p_rda; rda |=> o_reg_rdata == $past(ra_q); endproperty
    a_rda: assert property (p_rda) else $error("readback wrong");
    property p_rdb; rdb |=> o_reg_rdata == {1'b0, $past(rb_q)}; endproperty
    a_rdb: assert property (p_rdb) else $error("unused bit not zero");
    property p_rel; (i_ce && rb_q[5:4] == 2'h0) [*3] |-> !o_cs_relative; endproperty
    a_rel: assert property (p_rel) else $error("relative sense while off");
    property p_abs; (i_ce && rb_q[3:0] == 4'h8) [*3] |-> !o_cs_absolute; endproperty
    a_abs: assert property (p_abs) else $error("absolute sense while off");
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the gain and carrier sense configuration block
`timescale 1ns/1ps
module tb_top;
    reg              i_clk_sys = 1'b0;
    reg              i_rst = 1'b1;
    reg              i_ce = 1'b1;
    reg              i_reg_wr = 1'b0;
    reg              i_reg_rd = 1'b0;
    reg              i_rssi_valid = 1'b0;
    reg        [5:0] i_reg_addr = 6'h00;
    reg        [7:0] i_reg_wdata = 8'h00;
    reg        [7:0] i_gain_reduce_db = 8'h00;
    reg signed [7:0] i_rssi_db = 8'sh00;
    reg        [7:0] d;
    wire       [7:0] o_rdata, o_cut;
    wire       [2:0] o_top;
    wire       [5:0] o_sp;
    wire             o_ord, o_cs, o_csa, o_csr;
    integer          miscompares = 0, n_compared = 0, seed = 32'h8ab6, i, k, r, sp;
    agcs_top i_agcs_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_rdata), .i_rssi_valid(i_rssi_valid),
        .i_rssi_db(i_rssi_db), .i_gain_reduce_db(i_gain_reduce_db),
        .o_digital_gain_top_step(o_top), .o_front_amp_cut_tenth_db(o_cut),
        .o_amplitude_setpoint_db(o_sp), .o_reduce_first_amp_first(o_ord),
        .o_carrier_sense(o_cs), .o_cs_absolute(o_csa), .o_cs_relative(o_csr));
    initial forever #2 i_clk_sys = ~i_clk_sys;
    function [7:0] cut_f(input [2:0] c);
        cut_f = 64'hab92735c4a3d1a00 >> (c * 8);
    endfunction
    function [7:0] sp_f(input [2:0] c);
        sp_f = 64'h2a282624211e1b18 >> (c * 8);
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Two idle edges after a write so decodes and thresholds settle
    task wr(input [5:0] a, input [7:0] v);
        begin
            i_reg_addr = a;
            i_reg_wdata = v;
            i_reg_wr = 1'b1;
            @(negedge i_clk_sys) i_reg_wr = 1'b0;
            repeat (2) @(negedge i_clk_sys);
        end
    endtask
    task rd(input [5:0] a, input [7:0] exp);
        begin
            i_reg_addr = a;
            i_reg_rd = 1'b1;
            @(negedge i_clk_sys) i_reg_rd = 1'b0;
            chk(o_rdata, exp);
            @(negedge i_clk_sys);
        end
    endtask
    task smp(input integer v, input ea, input er);
        begin
            i_rssi_db = v[7:0];
            i_rssi_valid = 1'b1;
            @(negedge i_clk_sys) i_rssi_valid = 1'b0;
            chk(o_csa, ea);
            chk(o_csr, er);
            chk(o_cs, ea | er);
            @(negedge i_clk_sys);
        end
    endtask
    task wrap_up;
        begin
            $display("Compared %0d, mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #20000;
        miscompares = miscompares + 1;
        wrap_up;
    end
    initial begin
        repeat (4) @(negedge i_clk_sys);
        i_rst = 1'b0;
        @(negedge i_clk_sys);
        chk(o_top, 8'h07);
        chk(o_cut, 8'h00);
        chk(o_sp, 8'h21);
        chk(o_ord, 8'h01);
        rd(6'h1b, 8'h03);
        rd(6'h1c, 8'h40);
        for (i = 0; i < 8; i = i + 1) begin
            d = {i[1:0], 3'h7 - i[2:0], i[2:0]};
            wr(6'h1b, d);
            chk(o_top, 3'h7 - d[7:6]);
            chk(o_cut, cut_f(d[5:3]));
            chk(o_sp, sp_f(d[2:0]));
            rd(6'h1b, d);
        end
        sp = sp_f(d[2:0]);
        wr(6'h1c, 8'hff);
        chk(o_ord, 8'h01);
        rd(6'h1c, 8'h7f);
        wr(6'h3f, 8'hff);
        rd(6'h3f, 8'h00);
        // Enable low: a write must leave fields and decodes untouched
        i_ce = 1'b0;
        wr(6'h1b, 8'h00);
        chk(o_top, 8'h04);
        i_ce = 1'b1;
        rd(6'h1b, d);
        // Random gain cut shifts the absolute threshold by the same dB
        for (k = -7; k < 8; k = k + 1) begin
            r = $random(seed) & 7;
            i_gain_reduce_db = r[7:0];
            wr(6'h1c, {4'h0, k[3:0]});
            smp(sp + k + r - 1, 1'b0, 1'b0);
            smp(sp + k + r, 1'b1, 1'b0);
        end
        // Deepest cut with highest offset must not wrap to a low threshold
        i_gain_reduce_db = 8'hff;
        wr(6'h1c, 8'h07);
        smp(127, 1'b0, 1'b0);
        i_gain_reduce_db = 8'h00;
        wr(6'h1c, 8'h09);
        smp(-100, 1'b0, 1'b0);
        smp(sp - 7, 1'b1, 1'b0);
        chk(o_ord, 8'h00);
        wr(6'h1c, 8'h08);
        smp(127, 1'b0, 1'b0);
        for (k = 1; k < 4; k = k + 1) begin
            r = 4 * k + 2;
            i = -60 - 16 * k + ($random(seed) & 15);
            wr(6'h1c, {2'h0, k[1:0], 4'h8});
            smp(i, 1'b0, 1'b0);
            smp(i + r - 1, 1'b0, 1'b0);
            smp(i + 2 * r - 1, 1'b0, 1'b1);
        end
        wr(6'h1c, 8'h08);
        smp(100, 1'b0, 1'b0);
        wrap_up;
    end
endmodule
bind agcs_top agcs_checker i_agcs_checker (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_digital_gain_top_step(o_digital_gain_top_step),
    .o_front_amp_cut_tenth_db(o_front_amp_cut_tenth_db),
    .o_amplitude_setpoint_db(o_amplitude_setpoint_db),
    .o_reduce_first_amp_first(o_reduce_first_amp_first),
    .o_cs_absolute(o_cs_absolute), .o_cs_relative(o_cs_relative));

// File: hw/agcs_carrier_sense.v
// Carrier sense detector: absolute and relative threshold compare
`timescale 1ns/1ps
`include "agcs_map.vh"

module agcs_carrier_sense (
    // Clock, reset, enable
    input  wire                 i_clk_sys,
    input  wire                 i_rst,
    input  wire                 i_ce,
    // Signal strength sample
    input  wire                 i_rssi_valid,
    input  wire signed [7:0]    i_rssi_db,
    // Thresholds from the configuration
    input  wire                 i_abs_enable,
    input  wire signed [8:0]    i_abs_thr_db,
    input  wire [1:0]           i_rel_code,
    // Detector results
    output reg                  o_cs_abs,
    output reg                  o_cs_rel
);

    reg signed [7:0]  base_q;
    reg signed [8:0]  rise;
    reg [8:0]         rel_thr;
    reg               rel_hit;

    always @* begin
        rise = {i_rssi_db[7], i_rssi_db} - {base_q[7], base_q};
        case (i_rel_code)
            2'h1:    rel_thr = `AGCS_REL_RISE_1;
            2'h2:    rel_thr = `AGCS_REL_RISE_2;
            default: rel_thr = `AGCS_REL_RISE_3;
        endcase
        rel_hit = (i_rel_code != 2'h0) && (rise >= $signed(rel_thr));
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            base_q   <= 8'sh00;
            o_cs_abs <= 1'b0;
            o_cs_rel <= 1'b0;
        end else if (i_ce) begin
            if (!i_abs_enable) begin
                o_cs_abs <= 1'b0;
            end else if (i_rssi_valid) begin
                o_cs_abs <= ($signed({i_rssi_db[7], i_rssi_db}) >= i_abs_thr_db);
            end
            if (i_rel_code == 2'h0) begin
                o_cs_rel <= 1'b0;
                if (i_rssi_valid) begin
                    base_q <= i_rssi_db;
                end
            end else if (i_rssi_valid) begin
                o_cs_rel <= rel_hit;
                // Baseline frozen while a rise is held, so it is not chased away
                if (!rel_hit) begin
                    base_q <= i_rssi_db;
                end
            end
        end
    end

endmodule

// File: hw/agcs_map.vh
// Register offsets, field positions, reset values and decode constants
`ifndef AGCS_MAP_VH
`define AGCS_MAP_VH

// Register offsets on the serial register port
`define AGCS_ADDR_W              6
`define AGCS_OFS_CEIL_SETPOINT   6'h1b
`define AGCS_OFS_ORDER_THRESH    6'h1c

// Gain ceiling and setpoint register fields
`define AGCS_DIG_CEIL_HI         7
`define AGCS_DIG_CEIL_LO         6
`define AGCS_FRONT_CEIL_HI       5
`define AGCS_FRONT_CEIL_LO       3
`define AGCS_SETPOINT_HI         2
`define AGCS_SETPOINT_LO         0

// Gain order and carrier threshold register fields
`define AGCS_UNUSED_BIT          7
`define AGCS_ORDER_BIT           6
`define AGCS_REL_THR_HI          5
`define AGCS_REL_THR_LO          4
`define AGCS_ABS_THR_HI          3
`define AGCS_ABS_THR_LO          0

// Reset values
`define AGCS_RST_DIG_CEIL        2'h0
`define AGCS_RST_FRONT_CEIL      3'h0
`define AGCS_RST_SETPOINT        3'h3
`define AGCS_RST_ORDER           1'h1
`define AGCS_RST_REL_THR         2'h0
`define AGCS_RST_ABS_THR         4'h0
`define AGCS_RST_SETPOINT_DB     6'h21
`define AGCS_RST_ABS_THR_DB      9'h021

// Digital gain step range and absolute threshold disable code
`define AGCS_DIG_TOP_STEP        3'h7
`define AGCS_ABS_THR_OFF         4'h8

// Threshold ceiling in dB; no signed RSSI sample can reach it
`define AGCS_THR_CEIL_DB         9'h0ff

// Relative rise thresholds in dB
`define AGCS_REL_RISE_1          9'h006
`define AGCS_REL_RISE_2          9'h00a
`define AGCS_REL_RISE_3          9'h00e

`endif

// File: hw/agcs_top.v
// Gain control and carrier sense configuration registers with decode
`timescale 1ns/1ps
`include "agcs_map.vh"

module agcs_top (
    // Clock, reset, enable
    input  wire                         i_clk_sys,
    input  wire                         i_rst,
    input  wire                         i_ce,
    // Serial register port access
    input  wire [`AGCS_ADDR_W-1:0]      i_reg_addr,
    input  wire                         i_reg_wr,
    input  wire                         i_reg_rd,
    input  wire [7:0]                   i_reg_wdata,
    output reg  [7:0]                   o_reg_rdata,
    // Gain control status
    input  wire                         i_rssi_valid,
    input  wire signed [7:0]            i_rssi_db,
    input  wire [7:0]                   i_gain_reduce_db,
    // Gain control settings
    output reg  [2:0]                   o_digital_gain_top_step,
    output reg  [7:0]                   o_front_amp_cut_tenth_db,
    output reg  [5:0]                   o_amplitude_setpoint_db,
    output reg                          o_reduce_first_amp_first,
    // Carrier sense
    output wire                         o_carrier_sense,
    output wire                         o_cs_absolute,
    output wire                         o_cs_relative
);

    // Configuration fields
    reg [1:0]           digital_gain_ceiling_q;
    reg [2:0]           front_amp_gain_ceiling_q;
    reg [2:0]           amplitude_setpoint_q;
    reg                 gain_reduction_order_q;
    reg [1:0]           carrier_relative_threshold_q;
    reg [3:0]           carrier_absolute_threshold_q;

    // Decode helpers
    reg [7:0]           cut_d;
    reg [5:0]           setpoint_d;
    reg [7:0]           rdata_d;
    reg signed [8:0]    abs_thr_q;
    reg                 abs_en_q;
    reg [9:0]           thr_sum_d;
    reg [8:0]           thr_clamp_d;

    wire                wr_ceil  = i_reg_wr && (i_reg_addr == `AGCS_OFS_CEIL_SETPOINT);
    wire                wr_order = i_reg_wr && (i_reg_addr == `AGCS_OFS_ORDER_THRESH);

    // Register writes
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            digital_gain_ceiling_q       <= `AGCS_RST_DIG_CEIL;
            front_amp_gain_ceiling_q     <= `AGCS_RST_FRONT_CEIL;
            amplitude_setpoint_q         <= `AGCS_RST_SETPOINT;
            gain_reduction_order_q       <= `AGCS_RST_ORDER;
            carrier_relative_threshold_q <= `AGCS_RST_REL_THR;
            carrier_absolute_threshold_q <= `AGCS_RST_ABS_THR;
        end else if (i_ce) begin
            if (wr_ceil) begin
                digital_gain_ceiling_q   <= i_reg_wdata[`AGCS_DIG_CEIL_HI:`AGCS_DIG_CEIL_LO];
                front_amp_gain_ceiling_q <=
                    i_reg_wdata[`AGCS_FRONT_CEIL_HI:`AGCS_FRONT_CEIL_LO];
                amplitude_setpoint_q     <= i_reg_wdata[`AGCS_SETPOINT_HI:`AGCS_SETPOINT_LO];
            end
            // Unused top bit has no storage, so a write to it is simply dropped
            if (wr_order) begin
                gain_reduction_order_q       <= i_reg_wdata[`AGCS_ORDER_BIT];
                carrier_relative_threshold_q <=
                    i_reg_wdata[`AGCS_REL_THR_HI:`AGCS_REL_THR_LO];
                carrier_absolute_threshold_q <=
                    i_reg_wdata[`AGCS_ABS_THR_HI:`AGCS_ABS_THR_LO];
            end
        end
    end

    // Read data mux
    always @* begin
        case (i_reg_addr)
            `AGCS_OFS_CEIL_SETPOINT: begin
                rdata_d = {digital_gain_ceiling_q, front_amp_gain_ceiling_q,
                           amplitude_setpoint_q};
            end
            `AGCS_OFS_ORDER_THRESH: begin
                rdata_d = {1'b0, gain_reduction_order_q,
                           carrier_relative_threshold_q, carrier_absolute_threshold_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_ce && i_reg_rd) begin
            o_reg_rdata <= rdata_d;
        end
    end

    // Front amp ceiling in tenths of a dB below full gain
    always @* begin
        case (front_amp_gain_ceiling_q)
            3'h0:    cut_d = 8'h00;
            3'h1:    cut_d = 8'h1a;
            3'h2:    cut_d = 8'h3d;
            3'h3:    cut_d = 8'h4a;
            3'h4:    cut_d = 8'h5c;
            3'h5:    cut_d = 8'h73;
            3'h6:    cut_d = 8'h92;
            3'h7:    cut_d = 8'hab;
            default: cut_d = 8'h00;
        endcase
    end

    // Averaged amplitude target in dB
    always @* begin
        case (amplitude_setpoint_q)
            3'h0:    setpoint_d = 6'h18;
            3'h1:    setpoint_d = 6'h1b;
            3'h2:    setpoint_d = 6'h1e;
            3'h3:    setpoint_d = 6'h21;
            3'h4:    setpoint_d = 6'h24;
            3'h5:    setpoint_d = 6'h26;
            3'h6:    setpoint_d = 6'h28;
            3'h7:    setpoint_d = 6'h2a;
            default: setpoint_d = 6'h21;
        endcase
    end

    // Registered decodes; one cycle after a write the gain loop sees new limits
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_digital_gain_top_step  <= `AGCS_DIG_TOP_STEP;
            o_front_amp_cut_tenth_db <= 8'h00;
            o_amplitude_setpoint_db  <= `AGCS_RST_SETPOINT_DB;
            o_reduce_first_amp_first <= 1'b1;
        end else if (i_ce) begin
            o_digital_gain_top_step  <= `AGCS_DIG_TOP_STEP - {1'b0, digital_gain_ceiling_q};
            o_front_amp_cut_tenth_db <= cut_d;
            o_amplitude_setpoint_db  <= setpoint_d;
            o_reduce_first_amp_first <= gain_reduction_order_q;
        end
    end

    // Sum one bit wider than the compare, so a deep gain cut cannot wrap negative
    always @* begin
        thr_sum_d = {4'h0, setpoint_d}
                  + {{6{carrier_absolute_threshold_q[3]}}, carrier_absolute_threshold_q}
                  + {2'b00, i_gain_reduce_db};
        if (thr_sum_d[9:8] != 2'b00) begin
            thr_clamp_d = `AGCS_THR_CEIL_DB;
        end else begin
            thr_clamp_d = thr_sum_d[8:0];
        end
    end

    // Absolute carrier threshold and enable lag the fields by one edge, like the gain decodes; the relative code does not
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            abs_thr_q <= `AGCS_RST_ABS_THR_DB;
            abs_en_q  <= 1'b1;
        end else if (i_ce) begin
            abs_en_q  <= (carrier_absolute_threshold_q != `AGCS_ABS_THR_OFF);
            // RSSI carries the gain cut, so the threshold moves up by it
            abs_thr_q <= $signed(thr_clamp_d);
        end
    end

    agcs_carrier_sense u_cs (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_rssi_valid (i_rssi_valid),
        .i_rssi_db    (i_rssi_db),
        .i_abs_enable (abs_en_q),
        .i_abs_thr_db (abs_thr_q),
        .i_rel_code   (carrier_relative_threshold_q),
        .o_cs_abs     (o_cs_absolute),
        .o_cs_rel     (o_cs_relative)
    );

    assign o_carrier_sense = o_cs_absolute | o_cs_relative;

endmodule
